// [hdl/owb_byte_cmd.sv]
// write-byte and read-byte command engine for a single-wire line master
// assumes an i2c front end on mclk_i that decodes bytes and scl edges,
// and an open-drain line with its own clock owc_clk_i
`timescale 1ns/100ps
module owb_byte_cmd
	import owb_pkg::*;
(
	input  wire logic        mclk_i,           // host side clock
	input  wire logic        rst_i,            // asynchronous reset, high
	input  wire logic        owc_clk_i,        // line side clock
	input  wire logic        cmd_stb_i,        // command code byte received
	input  wire logic [7:0]  cmd_code_i,       // command code
	input  wire logic        data_stb_i,       // data byte lsb scl fall
	input  wire logic [7:0]  data_i,           // data byte
	input  wire logic        ack_fall_stb_i,   // scl fall of command ack bit
	input  wire logic        overdrive_speed_select_i,
	input  wire logic        strong_pullup_enable_i,
	input  wire logic        active_pullup_enable_i,
	input  wire logic [11:0] write_zero_low_time_i,  // line clock cycles
	input  wire logic [11:0] recovery_time_i,        // line clock cycles
	input  wire logic        weak_pullup_resistance_i,
	input  wire logic        dq_i,             // line level
	output logic             dq_o,             // line drive value
	output logic             dq_oe_n_o,        // low while pulling low
	output logic             strong_pull_o,    // strong pull-up on
	output logic             active_pull_o,    // active pull-up burst
	output logic             wpu_sel_o,        // weak pull-up selection
	output logic             cmd_ack_o,        // ack the command code
	output logic             data_ack_o,       // ack the data byte
	output logic             rd_ptr_status_o,  // pointer to status, pulse
	output logic             line_busy_flag_o, // busy flag
	output logic [7:0]       read_data_o       // read-data register
);
	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,  // waiting for a command
		H_WDATA = 2'b01,  // write code taken, waiting for data byte
		H_RACK  = 2'b10,  // read code taken, waiting for ack scl fall
		H_RUN   = 2'b11   // line activity in progress
	} host_st_t;

	// ---------------- host clock domain ----------------
	host_st_t    hst_r;        // host side state
	host_st_t    hst_nxt;      // its next value
	logic        busy_r;       // line busy flag
	logic        start_tgl_r;  // start request toggle
	logic        done_seen_r;  // last done toggle seen
	logic        done_s;       // synchronised done toggle
	logic [7:0]  rdata_r;      // read-data register
	logic [7:0]  wbyte_r;      // held write byte
	logic [7:0]  rd_shift_r;   // line side sampled bits, first ends in bit 0
	logic        is_read_r;    // held command kind
	logic        od_h_r;       // held speed select
	logic        strong_h_r;   // held strong pull-up enable
	logic        active_h_r;   // held active pull-up enable
	logic        wpu_h_r;      // held weak pull-up selection
	logic [11:0] wzl_h_r;      // held write-zero low time
	logic [11:0] rec_h_r;      // held recovery time
	wire         known_cmd;    // code is one of ours
	wire         cmd_take;     // command accepted this cycle
	wire         launch;       // line activity requested this cycle
	wire         done_evt;     // line side finished

	// refuse while busy or mid-command
	assign known_cmd  = (cmd_code_i == CMD_WRITE_BYTE) || (cmd_code_i == CMD_READ_BYTE);
	assign cmd_take   = cmd_stb_i && known_cmd && (hst_r == H_IDLE) && !busy_r;
	assign cmd_ack_o  = cmd_take;
	assign data_ack_o = data_stb_i && (hst_r == H_WDATA);
	assign rd_ptr_status_o = cmd_take;
	// write waits for the full byte, read for the ack scl fall
	assign launch     = (data_stb_i && (hst_r == H_WDATA))
		|| (ack_fall_stb_i && (hst_r == H_RACK));
	assign done_evt   = (done_s != done_seen_r);
	assign line_busy_flag_o = busy_r;
	assign read_data_o      = rdata_r;

	// host side state sequence
	always_comb begin
		hst_nxt = hst_r;
		unique case (hst_r)
			H_IDLE: begin
				if (cmd_take) begin
					hst_nxt = (cmd_code_i == CMD_WRITE_BYTE) ? H_WDATA : H_RACK;
				end
			end
			H_WDATA: begin
				if (launch) begin
					hst_nxt = H_RUN;
				end
			end
			H_RACK: begin
				if (launch) begin
					hst_nxt = H_RUN;
				end
			end
			H_RUN: begin
				if (done_evt) begin
					hst_nxt = H_IDLE;
				end
			end
		endcase
	end

	// state and busy flag
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			hst_r       <= H_IDLE;
			busy_r      <= 1'b0;
			done_seen_r <= 1'b0;
		end else begin
			hst_r       <= hst_nxt;
			done_seen_r <= done_s;
			if (launch) begin
				busy_r <= 1'b1;
			end else if (done_evt) begin
				busy_r <= 1'b0;
			end
		end
	end

	// command capture: kind, byte and the current settings
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			is_read_r <= 1'b0;
			wbyte_r   <= 8'h00;
			od_h_r    <= 1'b0;
			strong_h_r <= 1'b0;
			active_h_r <= 1'b0;
			wpu_h_r   <= 1'b0;
			wzl_h_r   <= 12'h000;
			rec_h_r   <= 12'h000;
		end else begin
			if (cmd_take) begin
				is_read_r <= (cmd_code_i == CMD_READ_BYTE);
			end
			if (data_stb_i && (hst_r == H_WDATA)) begin
				wbyte_r <= data_i;
			end
			if (cmd_take) begin
				od_h_r  <= overdrive_speed_select_i;
				strong_h_r <= strong_pullup_enable_i;
				active_h_r <= active_pullup_enable_i;
				wpu_h_r <= weak_pullup_resistance_i;
				wzl_h_r <= write_zero_low_time_i;
				rec_h_r <= recovery_time_i;
			end
		end
	end

	// start toggle and read-data register
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			start_tgl_r <= 1'b0;
			rdata_r     <= 8'h00;
		end else begin
			if (launch) begin
				start_tgl_r <= !start_tgl_r;
			end
			if (done_evt && is_read_r) begin
				rdata_r <= rd_shift_r;
			end
		end
	end

	// ---------------- line clock domain ----------------
	logic        start_s;      // synchronised start toggle
	logic        start_seen_r; // last start toggle seen
	logic        dq_s;         // synchronised line level
	logic        lrun_r;       // byte in progress
	logic [2:0]  slot_idx_r;   // slot number within the byte
	logic [7:0]  wshift_r;     // outgoing bits, lsb next
	logic        done_tgl_r;   // done toggle
	logic        strong_r;     // strong pull-up output
	logic [11:0] burst_cnt_r;  // active pull-up burst counter
	logic        burst_r;      // active pull-up output
	logic        wpu_r;        // weak pull-up output
	logic        slot_go_r;    // start pulse for the next slot
	logic        slot_oe_n;    // slot line drive
	logic        slot_sample;  // slot sample pulse
	logic        slot_rel;     // slot release pulse
	logic        slot_done;    // slot finished
	logic        slot_run;     // slot running
	wire         start_evt;    // new byte requested
	wire         slot_bit;     // value of the current slot
	wire         last_done;    // final slot and recovery finished

	assign start_evt = (start_s != start_seen_r);
	// a read slot is a write-one slot
	assign slot_bit  = is_read_r || wshift_r[0];
	assign last_done = slot_done && (slot_idx_r == LAST_SLOT);
	assign dq_o      = 1'b0;
	assign dq_oe_n_o = slot_oe_n;
	assign strong_pull_o = strong_r;
	assign active_pull_o = burst_r;
	assign wpu_sel_o = wpu_r;

	owb_sync3 u_start_sync (
		.clk_i (owc_clk_i),
		.rst_i (rst_i),
		.d_i   (start_tgl_r),
		.q_o   (start_s)
	);

	owb_sync3 u_done_sync (
		.clk_i (mclk_i),
		.rst_i (rst_i),
		.d_i   (done_tgl_r),
		.q_o   (done_s)
	);

	owb_sync3 u_dq_sync (
		.clk_i (owc_clk_i),
		.rst_i (rst_i),
		.d_i   (dq_i),
		.q_o   (dq_s)
	);

	owb_slot u_slot (
		.clk_i     (owc_clk_i),
		.rst_i     (rst_i),
		.go_i      (slot_go_r),
		.bit_i     (slot_bit),
		.od_i      (od_h_r),
		.wzl_cyc_i (wzl_h_r),
		.rec_cyc_i (rec_h_r),
		.oe_n_o    (slot_oe_n),
		.sample_o  (slot_sample),
		.release_o (slot_rel),
		.done_o    (slot_done),
		.run_o     (slot_run)
	);

	// byte sequencer: eight slots back to back, then the done toggle
	always_ff @(posedge owc_clk_i or posedge rst_i) begin
		if (rst_i) begin
			start_seen_r <= 1'b0;
			lrun_r       <= 1'b0;
			slot_idx_r   <= 3'h0;
			slot_go_r    <= 1'b0;
			done_tgl_r   <= 1'b0;
		end else begin
			start_seen_r <= start_s;
			slot_go_r    <= 1'b0;
			if (start_evt && !lrun_r) begin
				lrun_r     <= 1'b1;
				slot_idx_r <= 3'h0;
				slot_go_r  <= 1'b1;
			end else if (last_done) begin
				lrun_r     <= 1'b0;
				done_tgl_r <= !done_tgl_r;
			end else if (slot_done) begin
				slot_idx_r <= slot_idx_r + 3'h1;
				slot_go_r  <= 1'b1;
			end
		end
	end

	// outgoing and sampled bit shifters
	always_ff @(posedge owc_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wshift_r   <= 8'h00;
			rd_shift_r <= 8'h00;
		end else begin
			if (start_evt && !lrun_r) begin
				wshift_r <= wbyte_r;
			end else if (slot_done) begin
				wshift_r <= {1'b0, wshift_r[7:1]};
			end
			if (slot_sample) begin
				rd_shift_r <= {dq_s, rd_shift_r[7:1]};
			end
		end
	end

	// pull-up controls: strong after a write byte, active on each release
	always_ff @(posedge owc_clk_i or posedge rst_i) begin
		if (rst_i) begin
			strong_r    <= 1'b0;
			burst_cnt_r <= 12'h000;
			burst_r     <= 1'b0;
			wpu_r       <= 1'b0;
		end else begin
			wpu_r <= wpu_h_r;
			if (start_evt) begin
				strong_r <= 1'b0;
			end else if (last_done && !is_read_r && strong_h_r) begin
				strong_r <= 1'b1;
			end
			if (slot_rel && active_h_r) begin
				burst_cnt_r <= BURST_CYC;
			end else if (burst_cnt_r != 12'h000) begin
				burst_cnt_r <= burst_cnt_r - 12'h001;
			end
			burst_r <= (slot_rel && active_h_r) || (burst_cnt_r > 12'h001);
		end
	end

	// ---------------- checks ----------------
	chk_busy_no_ack: assert property (@(posedge mclk_i) disable iff (rst_i)
		(cmd_stb_i && busy_r) |-> !cmd_ack_o && !rd_ptr_status_o)
		else $error("command acknowledged while busy");

	chk_wdata_refused: assert property (@(posedge mclk_i) disable iff (rst_i)
		(data_stb_i && hst_r != H_WDATA) |-> !data_ack_o)
		else $error("data byte acknowledged without pending write");

	chk_launch_busy: assert property (@(posedge mclk_i) disable iff (rst_i)
		launch |=> busy_r && (hst_r == H_RUN) && $changed(start_tgl_r))
		else $error("launch did not raise busy");

	chk_busy_until_done: assert property (@(posedge mclk_i) disable iff (rst_i)
		$fell(busy_r) |-> $past(done_evt) && (hst_r == H_IDLE))
		else $error("busy cleared without line done");

	chk_read_capture: assert property (@(posedge mclk_i) disable iff (rst_i)
		(done_evt && is_read_r) |=> rdata_r == $past(rd_shift_r))
		else $error("read data not captured at done");

	chk_slot_order: assert property (@(posedge owc_clk_i) disable iff (rst_i)
		(slot_go_r && !is_read_r) |-> slot_bit == wbyte_r[slot_idx_r])
		else $error("write slot not taken from lsb");

	chk_read_one: assert property (@(posedge owc_clk_i) disable iff (rst_i)
		(slot_go_r && is_read_r) |-> slot_bit)
		else $error("read slot not a write-one slot");

	chk_fast_start: assert property (@(posedge owc_clk_i) disable iff (rst_i)
		(start_evt && !lrun_r) |=> slot_go_r ##1 !dq_oe_n_o)
		else $error("line activity did not start promptly");

	chk_eight_slots: assert property (@(posedge owc_clk_i) disable iff (rst_i)
		$changed(done_tgl_r) |-> $past(slot_idx_r) == LAST_SLOT && !lrun_r && !slot_run)
		else $error("byte ended after wrong slot count");

	chk_no_strong_read: assert property (@(posedge owc_clk_i) disable iff (rst_i)
		(lrun_r && is_read_r) |-> !strong_r)
		else $error("strong pull-up during read byte");
endmodule

// [hdl/owb_pkg.sv]
// constants shared by the single-wire byte command block
// assumes the mclk domain runs at 50 MHz and the line clock near 48 ns
package owb_pkg;
	// command codes seen from the host front end
	localparam logic [7:0] CMD_WRITE_BYTE  = 8'hA5;
	localparam logic [7:0] CMD_READ_BYTE   = 8'h96;
	// clock periods in picoseconds
	localparam int         MCLK_PERIOD_PS  = 20000;
	localparam int         LINK_PERIOD_PS  = 48000;
	// latest start of line activity after the triggering scl edge
	localparam int         ACT_START_PS    = 262500;
	localparam int         ACT_START_CYC   = ACT_START_PS / MCLK_PERIOD_PS;
	// index of the last of the eight slots in one byte
	localparam logic [2:0] LAST_SLOT       = 3'h7;
	// slot timing in nanoseconds, standard and overdrive speed
	localparam int         STD_SLOT_NS     = 65000;
	localparam int         OD_SLOT_NS      = 9000;
	localparam int         STD_W1L_NS      = 6000;
	localparam int         OD_W1L_NS       = 1000;
	localparam int         STD_MSR_NS      = 9000;
	localparam int         OD_MSR_NS       = 1500;
	localparam int         BURST_NS        = 2500;

	// least time in ns to whole line clock cycles, never below one
	function automatic logic [11:0] link_cyc(input int ns);
		int c;
		c = (ns * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
		if (c < 1) begin
			c = 1;
		end
		return c[11:0];
	endfunction

	localparam logic [11:0] STD_SLOT_CYC   = link_cyc(STD_SLOT_NS);
	localparam logic [11:0] OD_SLOT_CYC    = link_cyc(OD_SLOT_NS);
	localparam logic [11:0] STD_W1L_CYC    = link_cyc(STD_W1L_NS);
	localparam logic [11:0] OD_W1L_CYC     = link_cyc(OD_W1L_NS);
	localparam logic [11:0] STD_MSR_CYC    = link_cyc(STD_MSR_NS);
	localparam logic [11:0] OD_MSR_CYC     = link_cyc(OD_MSR_NS);
	localparam logic [11:0] BURST_CYC      = link_cyc(BURST_NS);
endpackage

// [hdl/owb_slot.sv]
// one time slot generator on the line clock
// assumes go_i is a one-cycle pulse and the inputs hold for the slot
`timescale 1ns/100ps
module owb_slot
	import owb_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        go_i,        // start one slot
	input  wire logic        bit_i,       // 1 write-one/read, 0 write-zero
	input  wire logic        od_i,        // overdrive speed
	input  wire logic [11:0] wzl_cyc_i,   // write-zero low time
	input  wire logic [11:0] rec_cyc_i,   // recovery time
	output logic             oe_n_o,      // low while pulling the line low
	output logic             sample_o,    // sample point pulse
	output logic             release_o,   // line released pulse
	output logic             done_o,      // last cycle of slot and recovery
	output logic             run_o        // slot in progress
);
	logic        run_r;     // slot running
	logic [11:0] cnt_r;     // cycles since slot start
	logic        oe_n_r;    // registered line drive enable
	wire  [11:0] low_len;   // length of the low phase
	wire  [11:0] msr;       // sample point
	wire  [11:0] slot_end;  // length of slot plus recovery in cycles
	wire  [11:0] cnt_nxt;   // next count

	// low phase: short for a one, programmed for a zero
	assign low_len  = bit_i ? (od_i ? OD_W1L_CYC : STD_W1L_CYC) : wzl_cyc_i;
	assign msr      = od_i ? OD_MSR_CYC : STD_MSR_CYC;
	assign slot_end = (od_i ? OD_SLOT_CYC : STD_SLOT_CYC) + rec_cyc_i;
	assign cnt_nxt  = cnt_r + 12'h001;
	assign sample_o  = run_r && (cnt_r == msr);
	assign release_o = run_r && (cnt_r == low_len);
	assign done_o    = run_r && (cnt_nxt == slot_end);
	assign run_o     = run_r;
	assign oe_n_o    = oe_n_r;

	// slot counter and line drive
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			run_r  <= 1'b0;
			cnt_r  <= 12'h000;
			oe_n_r <= 1'b1;
		end else if (go_i) begin
			run_r  <= 1'b1;
			cnt_r  <= 12'h000;
			oe_n_r <= 1'b0;
		end else if (run_r) begin
			cnt_r  <= cnt_nxt;
			run_r  <= !done_o;
			oe_n_r <= !(cnt_nxt < low_len);
		end
	end

	// the sample point falls inside a running slot, released in a write-one slot
	chk_sample_in_slot: assert property (@(posedge clk_i) disable iff (rst_i)
		sample_o |-> run_r && (oe_n_r || !bit_i))
		else $error("sample taken outside released slot");
endmodule

// [hdl/owb_sync3.sv]
// three-stage synchroniser for a level or a toggle
// assumes d_i comes from another clock domain or a pin
`timescale 1ns/100ps
module owb_sync3 (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic s1_r;  // first stage, read only by the second
	logic s2_r;  // second stage
	logic s3_r;  // third stage
	logic q_r;   // accepted level, held while the stages disagree

	// a change counts once the second and third stages agree
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			q_r  <= 1'b0;
		end else begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				q_r <= s3_r;
			end
		end
	end

	// agreeing stages pass at once, saving a cycle of start latency
	assign q_o = (s2_r == s3_r) ? s3_r : q_r;
endmodule

// [verification/owb_line_slave.sv]
// line slave model: decodes master slots and answers read slots
// assumes a pulled-up wire whose level arrives on dq_i
`timescale 1ns/100ps
module owb_line_slave (
	input  wire logic       dq_i,        // wire level
	input  wire logic       od_i,        // overdrive timing
	input  wire logic       resp_en_i,   // answer slots from resp_byte_i
	input  wire logic [7:0] resp_byte_i, // answer, lsb first
	output logic            pull_low_o,  // pulls the wire low
	output logic [7:0]      rx_byte_o,   // bits seen, last one in bit 7
	output int              nslots_o     // slots seen
);
	// released at start, so the pull-up holds the wire high
	initial begin
		pull_low_o = 1'b0;
		rx_byte_o  = 8'h00;
		nslots_o   = 0;
	end

	// each falling edge opens a slot; a zero answer holds the wire past the sample point
	always @(negedge dq_i) begin
		if (resp_en_i && !resp_byte_i[nslots_o[2:0]]) begin
			pull_low_o = 1'b1;
		end
		// decode between the write-one and write-zero low times
		#(od_i ? 2000 : 15000);
		rx_byte_o = {dq_i, rx_byte_o[7:1]};
		#(od_i ? 1000 : 15000);
		pull_low_o = 1'b0;
		nslots_o   = nslots_o + 1;
	end
endmodule

// [verification/single_wire_byte_commands_bench.sv]
// bench for the byte command engine, with a slave model on the wire
// assumes the package, engine and slave model are compiled first
`timescale 1ns/100ps
module single_wire_byte_commands_bench
	import owb_pkg::*;
;
	logic        mclk     = 1'b0;  // host clock
	logic        lclk     = 1'b0;  // line clock
	logic        rst      = 1'b1;  // reset
	logic        cstb     = 1'b0;  // command strobe
	logic [7:0]  ccode    = 8'h00; // command code
	logic        dstb     = 1'b0;  // data strobe
	logic [7:0]  din      = 8'h00; // data byte
	logic        astb     = 1'b0;  // ack fall strobe
	logic        od       = 1'b1;  // overdrive
	logic        strong_en = 1'b0; // strong pull-up setting
	logic        active_en = 1'b0; // active pull-up setting
	logic        wpu      = 1'b0;  // weak pull-up setting
	logic [11:0] wzl      = 12'h040; // write-zero low
	logic [11:0] rec      = 12'h004; // recovery
	logic        resp_en  = 1'b0;  // slave answers
	logic [7:0]  resp     = 8'h00; // slave answer
	logic        oe_n, strong_q, burst_q, wpu_q, cack, dack, rptr, busy;
	logic        pull_low, dq_w, dq_drv;
	logic [7:0]  rdat, rx_byte;
	logic [7:0]  last_rd  = 8'h00; // last byte read
	logic [11:0] w1l      = 12'h000; // expected write-one low
	logic        zero_ok  = 1'b0;  // write-zero pulses allowed
	logic        burst_seen = 1'b0; // burst seen in this op
	int          nslots, low_len = 0, bad_len = 0, cyc = 0;
	int          fail_count = 0, n_compared = 0, seed = 34505;

	always #10 mclk = ~mclk;
	always #24 lclk = ~lclk;
	// pulled-up wire: low when either party pulls
	assign dq_w = oe_n & !pull_low;

	owb_byte_cmd owb_byte_cmd_i (
		.mclk_i(mclk), .rst_i(rst), .owc_clk_i(lclk), .cmd_stb_i(cstb), .cmd_code_i(ccode),
		.data_stb_i(dstb), .data_i(din), .ack_fall_stb_i(astb),
		.overdrive_speed_select_i(od), .strong_pullup_enable_i(strong_en),
		.active_pullup_enable_i(active_en), .write_zero_low_time_i(wzl), .recovery_time_i(rec),
		.weak_pullup_resistance_i(wpu), .dq_i(dq_w), .dq_o(dq_drv), .dq_oe_n_o(oe_n),
		.strong_pull_o(strong_q), .active_pull_o(burst_q), .wpu_sel_o(wpu_q), .cmd_ack_o(cack),
		.data_ack_o(dack),
		.rd_ptr_status_o(rptr), .line_busy_flag_o(busy), .read_data_o(rdat));

	owb_line_slave owb_line_slave_i (
		.dq_i(dq_w), .od_i(od), .resp_en_i(resp_en), .resp_byte_i(resp),
		.pull_low_o(pull_low), .rx_byte_o(rx_byte), .nslots_o(nslots));

	// measures each low pulse of the master and notes pull-up bursts,
	// on the falling edge so the registered outputs have settled
	always @(negedge lclk) begin
		if (burst_q === 1'b1) begin
			burst_seen = 1'b1;
		end
		if (oe_n === 1'b0) begin
			low_len++;
		end else if (low_len != 0) begin
			if (low_len != w1l && !(zero_ok && low_len == wzl)) begin
				bad_len++;
			end
			low_len = 0;
		end
	end

	// hang guard, well above the expected run
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 95000) begin
			fail_count++;
			close_out;
		end
	end

	task automatic close_out;
		if (fail_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// longest legal command duration in ns, start and return crossings included
	function automatic real op_limit(input int slot_cyc, input int rec_cyc);
		return 8.0 * (slot_cyc + rec_cyc + 1) * 48.0 + 462.5;
	endfunction

	// one byte command: accept, pending refusal, launch, busy refusals, completion
	task automatic run_op(input logic wr, input logic [7:0] d, input logic sp);
		real t0, lim, tb;
		int  n0, sc;
		@(negedge mclk);
		od = sp;
		{strong_en, active_en, wpu} = 3'($random(seed));
		wzl = sp ? 12'(60 + {$random(seed)} % 61) : 12'h4B0;
		rec = 12'(2 + {$random(seed)} % 19);
		resp_en = !wr;
		resp = d;
		burst_seen = 1'b0;
		bad_len = 0;
		w1l = sp ? OD_W1L_CYC : STD_W1L_CYC;
		zero_ok = wr;
		sc = sp ? OD_SLOT_CYC : STD_SLOT_CYC;
		cstb = 1'b1;
		ccode = wr ? CMD_WRITE_BYTE : CMD_READ_BYTE;
		#1 check(cack, 1'b1);
		check(rptr, 1'b1);
		@(negedge mclk);
		ccode = wr ? CMD_READ_BYTE : CMD_WRITE_BYTE;
		#1 check(cack, 1'b0);
		@(negedge mclk);
		cstb = 1'b0;
		repeat (1 + {$random(seed)} % 4) @(negedge mclk);
		dstb = wr;
		din = d;
		astb = !wr;
		#1 check(dack, wr);
		@(posedge mclk) t0 = $realtime;
		n0 = nslots;
		@(negedge mclk);
		dstb = 1'b0;
		astb = 1'b0;
		while (oe_n === 1'b1 && $realtime - t0 < 1000.0) #1;
		check($realtime - t0 <= ACT_START_PS / 1000.0, 1'b1);
		check(busy, 1'b1);
		@(negedge mclk);
		cstb = 1'b1;
		ccode = CMD_WRITE_BYTE;
		#1 check(cack, 1'b0);
		@(negedge mclk);
		ccode = CMD_READ_BYTE;
		#1 check(cack, 1'b0);
		@(negedge mclk);
		cstb = 1'b0;
		dstb = 1'b1;
		#1 check(dack, 1'b0);
		@(negedge mclk);
		dstb = 1'b0;
		lim = op_limit(sc, rec);
		while (busy === 1'b1 && $realtime - t0 < lim + 1000.0) @(negedge mclk);
		tb = $realtime - t0;
		check(tb >= 8.0 * sc * 48.0, 1'b1);
		check(tb <= lim, 1'b1);
		check(nslots - n0, 8);
		if (wr) begin
			check(rx_byte, d);
			check(strong_q, strong_en);
			check(rdat, last_rd);
		end else begin
			check(rdat, d);
			check(rx_byte, d);
			check(strong_q, 1'b0);
			last_rd = d;
		end
		check(burst_seen, active_en);
		check(wpu_q, wpu);
		check(bad_len, 0);
	endtask

	// reset, an unknown code, then back-to-back byte commands
	initial begin
		logic [7:0] d;
		repeat (8) @(posedge mclk);
		@(negedge mclk) rst = 1'b0;
		check(busy, 1'b0);
		check(rdat, 8'h00);
		check(oe_n, 1'b1);
		check(dq_drv, 1'b0);
		@(negedge mclk);
		cstb = 1'b1;
		ccode = 8'h3C;
		#1 check(cack, 1'b0);
		@(negedge mclk) cstb = 1'b0;
		// all-zero and all-one corners first, two standard-speed ops last
		for (int i = 0; i < 8; i++) begin
			d = (i < 2) ? 8'h00 : (i < 4) ? 8'hFF : 8'($random(seed));
			run_op(!i[0], d, i < 6);
		end
		close_out;
	end
endmodule
